// >>> inc/acw_pkg.sv
package acw_pkg;

    // register indexes; byte address is four times the index
    localparam logic [7:0]  ACW_IDX_RES_LO   = 8'hBE;
    localparam logic [7:0]  ACW_IDX_RES_HI   = 8'hBF;
    localparam logic [7:0]  ACW_IDX_GT_LO    = 8'hC4;
    localparam logic [7:0]  ACW_IDX_GT_HI    = 8'hC5;
    localparam logic [7:0]  ACW_IDX_LT_LO    = 8'hC6;
    localparam logic [7:0]  ACW_IDX_LT_HI    = 8'hC7;
    localparam logic [7:0]  ACW_IDX_CTRL     = 8'hE8;

    localparam int          ACW_ADDR_W       = 12;

    localparam logic [7:0]  ACW_RST_CTRL     = 8'h00;
    localparam logic [7:0]  ACW_RST_RES_HI   = 8'h00;
    localparam logic [7:0]  ACW_RST_RES_LO   = 8'h00;
    localparam logic [7:0]  ACW_RST_GT_HI    = 8'hFF;
    localparam logic [7:0]  ACW_RST_GT_LO    = 8'hFF;
    localparam logic [7:0]  ACW_RST_LT_HI    = 8'h00;
    localparam logic [7:0]  ACW_RST_LT_LO    = 8'h00;
    localparam logic [2:0]  ACW_RST_PIN_SYN  = 3'h7;
    localparam logic        ACW_RST_PIN_LVL  = 1'b1;

    // converter_control field positions
    localparam int          ACW_B_ENABLE     = 7;
    localparam int          ACW_B_TRKMODE    = 6;
    localparam int          ACW_B_DONE       = 5;
    localparam int          ACW_B_BUSY       = 4;
    localparam int          ACW_B_STM_HI     = 3;
    localparam int          ACW_B_STM_LO     = 2;
    localparam int          ACW_B_WINDOW     = 1;
    localparam int          ACW_B_LJUST      = 0;

    localparam logic [1:0]  ACW_STM_WRITE    = 2'h0;
    localparam logic [1:0]  ACW_STM_TIMER3   = 2'h1;
    localparam logic [1:0]  ACW_STM_PIN      = 2'h2;
    localparam logic [1:0]  ACW_STM_TIMER2   = 2'h3;

    // timing
    localparam int          ACW_CLK_HZ       = 50000000;
    localparam int          ACW_SAR_HZ_MAX   = 2500000;
    localparam int          ACW_SAR_DIV      = (ACW_CLK_HZ + ACW_SAR_HZ_MAX - 1) / ACW_SAR_HZ_MAX;
    localparam int          ACW_CONV_PERIODS = 16;
    localparam int          ACW_RES_W        = 10;
    localparam logic [4:0]  ACW_FIRST_BIT    = 5'h06;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  res_hi;
        logic [7:0]  res_lo;
        logic [7:0]  gt_hi;
        logic [7:0]  gt_lo;
        logic [7:0]  lt_hi;
        logic [7:0]  lt_lo;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [2:0]  pin_sync;
        logic        pin_level;
        logic        start;
    } acw_top_t;

    typedef struct packed {
        logic [2:0]  cmp_sync;
        logic        cmp_level;
        logic [7:0]  div;
        logic [4:0]  step;
        logic        busy;
        logic        done;
        logic        hold;
        logic [9:0]  trial;
        logic [9:0]  result;
    } acw_sar_t;

endpackage

// >>> rtl/acw_sar_seq.sv
`timescale 1ns/100ps
module acw_sar_seq
    import acw_pkg::*;
#(
    parameter int SAR_DIV = ACW_SAR_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        enable,
    input  wire logic        start,
    input  wire logic        cmp_in,
    output logic             busy,
    output logic             done,
    output logic             hold,
    output logic [9:0]       trial,
    output logic [9:0]       result
);
    acw_sar_t s_reg;
    acw_sar_t s_next;
    logic     tick;
    logic     cmp_ok;
    logic [3:0] bit_idx;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.cmp_sync = {s_reg.cmp_sync[1:0], cmp_in};
        tick = (s_reg.div == 8'(SAR_DIV - 1));
        // a comparator change counts once the last two stages agree
        cmp_ok = (s_reg.cmp_sync[1] == s_reg.cmp_sync[2]) ? s_reg.cmp_sync[2] : s_reg.cmp_level;
        s_next.cmp_level = cmp_ok;
        bit_idx = 4'(15 - s_reg.step);
        s_next.div = (tick || !s_reg.busy) ? 8'h00 : 8'(s_reg.div + 8'h01);
        if (!enable) begin
            s_next.busy = 1'b0;
            s_next.hold = 1'b0;
        end else if (!s_reg.busy) begin
            if (start) begin
                s_next.busy = 1'b1;
                s_next.step = 5'h00;
                s_next.hold = 1'b0;
                s_next.trial = 10'h200;
            end
        end else if (tick) begin
            // steps 0..5 track and settle, 6..15 resolve one bit each
            if (s_reg.step >= ACW_FIRST_BIT) begin
                if (!cmp_ok) begin
                    s_next.trial[bit_idx] = 1'b0;
                end
                if (bit_idx != 4'h0) begin
                    s_next.trial[bit_idx - 4'h1] = 1'b1;
                end
            end
            if (s_reg.step == ACW_FIRST_BIT - 5'h01) begin
                s_next.hold = 1'b1;
            end
            if (s_reg.step == 5'(ACW_CONV_PERIODS - 1)) begin // RQ7
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.hold = 1'b0;
                s_next.result = cmp_ok ? s_next.trial : (s_next.trial & 10'h3FE);
            end else begin
                s_next.step = 5'(s_reg.step + 5'h01);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy   = s_reg.busy;
    assign done   = s_reg.done;
    assign hold   = s_reg.hold;
    assign trial  = s_reg.trial;
    assign result = s_reg.result;
endmodule // acw_sar_seq

// >>> rtl/acw_window_ctrl.sv
//Contract
//[RQ1] compare every conversion result with both limit words and flag out-of-band
//[RQ2] window flag stays readable in the control register for polling
//[RQ3] software loads each limit word as separate high and low bytes
//[RQ4] limit ordering selects inside-window or outside-window flagging
//[RQ5] greater-than word is high byte register over low byte register
//[RQ6] greater-than low byte is the word's low eight bits, resets to all ones
//[RQ7] a conversion takes at least sixteen converter clock periods
//[RQ8] less above greater flags strictly between, else outside; software clears
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module acw_window_ctrl
    import acw_pkg::*;
#(
    parameter int SAR_DIV = ACW_SAR_DIV
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ACW_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  timer2_ovf,
    input  wire logic                  timer3_ovf,
    input  wire logic                  start_pin,
    input  wire logic                  cmp_in,
    output logic                       sar_hold,
    output logic [9:0]                 sar_trial
);
    acw_top_t   r_reg;
    acw_top_t   r_next;
    logic       busy;
    logic       done;
    logic [9:0] result;
    logic       setup;
    logic       wr;
    logic [6:0] sel;
    logic       hit;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;
    logic [15:0] res_word;
    logic [15:0] gt_word;
    logic [15:0] lt_word;
    logic       win_hit;
    logic       trig;
    logic       start_req;

    function automatic logic [15:0] justify(input logic [9:0] d, input logic left);
        justify = left ? {d, 6'h00} : {6'h00, d};
    endfunction

    // limit and result words share one {high, low} byte layout
    function automatic logic [15:0] byte_word(input logic [7:0] hi, input logic [7:0] lo);
        byte_word = {hi, lo};
    endfunction

    // less above greater marks a band to catch; otherwise the band is the safe region
    function automatic logic window_hit(input logic [15:0] r, input logic [15:0] g,
                                        input logic [15:0] l);
        if (l > g) begin // RQ4
            window_hit = (r > g) && (r < l); // RQ8
        end else begin
            window_hit = (r > g) || (r < l); // RQ8
        end
    endfunction

    // one-hot register select, shared by the read mux and the write strobe
    function automatic logic [6:0] reg_sel(input logic [ACW_ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        if ((a[1:0] != 2'h0) || (a[ACW_ADDR_W-1:10] != '0)) begin
            // misaligned, or an alias above the decoded window
            reg_sel = 7'h00;
        end else if (i == ACW_IDX_CTRL) begin
            reg_sel = 7'h01;
        end else if (i == ACW_IDX_RES_HI) begin
            reg_sel = 7'h02;
        end else if (i == ACW_IDX_RES_LO) begin
            reg_sel = 7'h04;
        end else if (i == ACW_IDX_GT_HI) begin
            reg_sel = 7'h08;
        end else if (i == ACW_IDX_GT_LO) begin
            reg_sel = 7'h10;
        end else if (i == ACW_IDX_LT_HI) begin
            reg_sel = 7'h20;
        end else if (i == ACW_IDX_LT_LO) begin
            reg_sel = 7'h40;
        end else begin
            reg_sel = 7'h00;
        end
    endfunction

    always_comb begin
        r_next  = r_reg;
        // a write lands only at the access edge, while ready stands
        setup   = psel && !penable;
        wr      = psel && penable && r_reg.pready && pwrite;
        sel     = reg_sel(paddr);
        wbyte   = pwdata[7:0];
        hit     = (sel != 7'h00);
        rd_byte = 8'h00;
        if (sel[0]) begin
            rd_byte = r_reg.ctrl;
            rd_byte[ACW_B_BUSY] = busy;
        end else if (sel[1]) begin
            rd_byte = r_reg.res_hi;
        end else if (sel[2]) begin
            rd_byte = r_reg.res_lo;
        end else if (sel[3]) begin
            rd_byte = r_reg.gt_hi;
        end else if (sel[4]) begin
            rd_byte = r_reg.gt_lo;
        end else if (sel[5]) begin
            rd_byte = r_reg.lt_hi;
        end else if (sel[6]) begin
            rd_byte = r_reg.lt_lo;
        end

        // answer one cycle after setup; ready drops after the access edge
        r_next.pready  = setup;
        r_next.pslverr = setup && !hit;
        if (setup) begin
            // byte frozen at setup; a result landing during access shows on the next read
            r_next.prdata = {24'h000000, hit ? rd_byte : 8'h00};
        end

        r_next.start = 1'b0;
        if (wr && hit) begin
            if (sel[0]) begin
                r_next.ctrl = wbyte;
                // the start bit is a strobe; busy reads back from the sequencer
                r_next.ctrl[ACW_B_BUSY] = 1'b0;
                r_next.start = wbyte[ACW_B_BUSY] && wbyte[ACW_B_ENABLE]
                    && (wbyte[ACW_B_STM_HI:ACW_B_STM_LO] == ACW_STM_WRITE);
            end else if (sel[1]) begin
                r_next.res_hi = wbyte;
            end else if (sel[2]) begin
                r_next.res_lo = wbyte;
            end else if (sel[3]) begin
                r_next.gt_hi = wbyte; // RQ3
            end else if (sel[4]) begin
                r_next.gt_lo = wbyte; // RQ6
            end else if (sel[5]) begin
                r_next.lt_hi = wbyte; // RQ3
            end else if (sel[6]) begin
                r_next.lt_lo = wbyte;
            end
        end

        // start pin level only changes once the last two stages agree
        r_next.pin_sync = {r_reg.pin_sync[1:0], start_pin};
        if (r_reg.pin_sync[1] == r_reg.pin_sync[2]) begin
            r_next.pin_level = r_reg.pin_sync[2];
        end
        // conversion begins when the tracking-low pin returns high
        case (r_reg.ctrl[ACW_B_STM_HI:ACW_B_STM_LO])
            ACW_STM_TIMER3: trig = timer3_ovf;
            ACW_STM_PIN:    trig = r_next.pin_level && !r_reg.pin_level;
            ACW_STM_TIMER2: trig = timer2_ovf;
            default:        trig = 1'b0;
        endcase
        // a trigger while busy is dropped by the sequencer, never queued
        start_req = r_reg.start || (trig && r_reg.ctrl[ACW_B_ENABLE]);

        // limits are compared against the justified word that software reads
        res_word = justify(result, r_reg.ctrl[ACW_B_LJUST]);
        gt_word  = byte_word(r_reg.gt_hi, r_reg.gt_lo); // RQ5
        lt_word  = byte_word(r_reg.lt_hi, r_reg.lt_lo);
        win_hit  = window_hit(res_word, gt_word, lt_word); // RQ1 RQ4

        // hardware set wins over a software clear in the same cycle
        if (done) begin
            r_next.res_hi = res_word[15:8];
            r_next.res_lo = res_word[7:0];
            r_next.ctrl[ACW_B_DONE] = 1'b1;
            if (win_hit) begin
                r_next.ctrl[ACW_B_WINDOW] = 1'b1; // RQ1 RQ2
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg           <= '0;
            r_reg.ctrl      <= ACW_RST_CTRL;
            r_reg.res_hi    <= ACW_RST_RES_HI;
            r_reg.res_lo    <= ACW_RST_RES_LO;
            r_reg.gt_hi     <= ACW_RST_GT_HI;
            r_reg.gt_lo     <= ACW_RST_GT_LO; // RQ6
            r_reg.lt_hi     <= ACW_RST_LT_HI;
            r_reg.lt_lo     <= ACW_RST_LT_LO;
            // pin idles high; starting there avoids a false edge after reset
            r_reg.pin_sync  <= ACW_RST_PIN_SYN;
            r_reg.pin_level <= ACW_RST_PIN_LVL;
        end else begin
            r_reg <= r_next;
        end
    end

    acw_sar_seq #(
        .SAR_DIV (SAR_DIV)
    ) u_sar (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (r_reg.ctrl[ACW_B_ENABLE]),
        .start   (start_req),
        .cmp_in  (cmp_in),
        .busy    (busy),
        .done    (done),
        .hold    (sar_hold),
        .trial   (sar_trial),
        .result  (result)
    );

    assign prdata  = r_reg.prdata;
    assign pready  = r_reg.pready;
    assign pslverr = r_reg.pslverr;
endmodule // acw_window_ctrl

// >>> tb/acw_sar_model.sv
`timescale 1ns/100ps
module acw_sar_model (
    input  wire logic       pclk,
    input  wire logic       sar_hold,
    input  wire logic [9:0] sar_trial,
    input  wire logic [9:0] vin,
    output logic            cmp_in
);
    logic [9:0] held_reg;

    // tracks while open, freezes while held so the code cannot drift mid-search
    always_ff @(posedge pclk) begin
        if (!sar_hold) begin
            held_reg <= vin;
        end
    end

    assign cmp_in = (held_reg >= sar_trial);
endmodule // acw_sar_model

// >>> tb/acw_window_monitor.sv
`timescale 1ns/100ps
module acw_window_monitor
    import acw_pkg::*;
#(
    parameter int SAR_DIV = ACW_SAR_DIV
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic [ACW_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           prdata,
    input  wire logic                  pready,
    input  wire logic                  pslverr,
    input  wire logic                  sar_hold,
    input  wire logic [9:0]            sar_trial
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [9:0] hold_cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_reg <= 10'h000;
        end else begin
            hold_cnt_reg <= sar_hold ? hold_cnt_reg + 10'h001 : 10'h000;
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence

    chk_ready_one_wait: assert property (s_setup |=> pready)
        else $error("no answer one cycle after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held over two cycles");
    chk_err_misalign: assert property (s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr)
        else $error("misaligned access not refused");
    chk_ctrl_mapped: assert property (s_setup ##0 (paddr == 12'h3A0) |=> !pslverr)
        else $error("control access refused");
    chk_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    chk_hold_trial: assert property ($rose(sar_hold) |-> sar_trial == 10'h200)
        else $error("trial word wrong at hold");
    chk_hold_min: assert property ($rose(sar_hold) |-> sar_hold [*8])
        else $error("hold too short");
    chk_hold_span: assert property ($fell(sar_hold) |->
        hold_cnt_reg inside {[9*SAR_DIV:11*SAR_DIV]})
        else $error("hold span off");
    chk_reset_idle: assert property ($rose(presetn) |-> !sar_hold && !pready)
        else $error("outputs busy after reset");
endmodule // acw_window_monitor

bind acw_window_ctrl acw_window_monitor #(.SAR_DIV(SAR_DIV)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sar_hold(sar_hold),
    .sar_trial(sar_trial));

// >>> tb/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb;
    import acw_pkg::*;
    localparam int DIV = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        t2, t3, spin, cmp, hold;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rng;
    logic [9:0]  trial, vin, gt, lt;
    logic [7:0]  c;
    int          miscompares, checks, cyc, t0;
    logic [7:0]  ix [7] = '{ACW_IDX_CTRL, ACW_IDX_RES_HI, ACW_IDX_RES_LO, ACW_IDX_GT_HI,
                            ACW_IDX_GT_LO, ACW_IDX_LT_HI, ACW_IDX_LT_LO};
    logic [7:0]  rv [7] = '{ACW_RST_CTRL, ACW_RST_RES_HI, ACW_RST_RES_LO, ACW_RST_GT_HI,
                            ACW_RST_GT_LO, ACW_RST_LT_HI, ACW_RST_LT_LO};
    // gt, lt, input: equal-to-limit cases must not flag
    logic [29:0] corner [4] = '{{10'h100, 10'h080, 10'h100}, {10'h100, 10'h080, 10'h07F},
                               {10'h080, 10'h300, 10'h300}, {10'h080, 10'h300, 10'h081}};

    acw_window_ctrl #(.SAR_DIV(DIV)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer2_ovf(t2),
        .timer3_ovf(t3), .start_pin(spin), .cmp_in(cmp), .sar_hold(hold),
        .sar_trial(trial));
    acw_sar_model u_core (.pclk(pclk), .sar_hold(hold), .sar_trial(trial), .vin(vin),
        .cmp_in(cmp));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction

    function automatic logic hit(input logic [15:0] r, g, l);
        return (l > g) ? (r > g && r < l) : (r > g || r < l);
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // read right after the edge, ready is the value that edge sampled
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic conv(input logic [1:0] m, input logic lj);
        int n;
        logic [15:0] rw;
        logic [15:0] gw;
        logic [15:0] lw;
        // limits are loaded in the same justification as the result
        rw = lj ? {vin, 6'h00} : {6'h00, vin};
        gw = lj ? {gt, 6'h00} : {6'h00, gt};
        lw = lj ? {lt, 6'h00} : {6'h00, lt};
        apb(1'b1, ad(ACW_IDX_GT_HI), gw[15:8]);
        apb(1'b1, ad(ACW_IDX_GT_LO), gw[7:0]);
        apb(1'b1, ad(ACW_IDX_LT_HI), lw[15:8]);
        apb(1'b1, ad(ACW_IDX_LT_LO), lw[7:0]);
        t0 = cyc;
        apb(1'b1, ad(ACW_IDX_CTRL), {3'h4, (m == 2'h0), m, 1'b0, lj});
        @(posedge pclk);
        t3 <= (m == ACW_STM_TIMER3);
        t2 <= (m == ACW_STM_TIMER2);
        spin <= (m != ACW_STM_PIN);
        @(posedge pclk);
        t3 <= 1'b0;
        t2 <= 1'b0;
        repeat (3) @(posedge pclk);
        spin <= 1'b1;
        n = 0;
        do begin
            apb(1'b0, ad(ACW_IDX_CTRL), 8'h00);
            n++;
        end while (rd[ACW_B_DONE] !== 1'b1 && n < 60);
        c = rd[7:0];
        `CHK("conv time", 1'b1, (cyc - t0) >= 16 * DIV)
        `CHK("window flag", hit(rw, gw, lw), c[ACW_B_WINDOW])
        apb(1'b0, ad(ACW_IDX_RES_HI), 8'h00);
        `CHK("result hi", rw[15:8], rd[7:0])
        apb(1'b0, ad(ACW_IDX_RES_LO), 8'h00);
        `CHK("result lo", rw[7:0], rd[7:0])
        apb(1'b1, ad(ACW_IDX_CTRL), 8'h80);
        apb(1'b0, ad(ACW_IDX_CTRL), 8'h00);
        `CHK("flags cleared", 2'h0, {rd[ACW_B_DONE], rd[ACW_B_WINDOW]})
    endtask

    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ceiling well above sixteen conversions of about a hundred cycles each
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            final_report;
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, t2, t3} = 6'h00;
        {paddr, pwdata, vin, cyc, miscompares, checks} = '0;
        spin = 1'b1;
        rng = 32'hF9BF94BE;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ad(ix[i]), 8'h00);
            `CHK("reset value", {24'h000000, rv[i]}, rd)
        end
        apb(1'b0, 12'h3A2, 8'h00);
        `CHK("misaligned err", 1'b1, err)
        `CHK("misaligned data", 32'h00000000, rd)
        apb(1'b0, 12'h000, 8'h00);
        `CHK("unmapped err", 1'b1, err)
        apb(1'b1, 12'hBA0, 8'h81);
        `CHK("alias err", 1'b1, err)
        apb(1'b0, ad(ACW_IDX_CTRL), 8'h00);
        `CHK("alias write ignored", {24'h000000, ACW_RST_CTRL}, rd)
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            if (i < 4) begin
                {gt, lt, vin} = corner[i];
            end else begin
                rng = xs(rng);
                {vin, lt, gt} = rng[29:0];
            end
            conv(i[1:0], i[2]);
        end
        $display("test conversions done");
        final_report;
    end
endmodule // tb
